/* include/fcdh_pkg.sv */
// package: constants and carriers for the flash command host controller
// What this block does
// - every command cycle is a bus write, except array reads and id read
// - one f0 write anywhere returns the flash to array reading; the host refuses it during chip erase, the model ignores it in sector erase
// - id entry: aa@555, 55@2aa, 90@555, then read maker code, device code or sector protection
// - program: unlock pair, a0@555, then location and value
// - in bypass, program is a0 anywhere then location and value
// - chip erase: unlock, 80@555, unlock, 10@555
// - sector erase: unlock, 80@555, unlock, 30 at sector address
// - extra sector/30 pairs must follow within 50 us
package fcdh_pkg;
	// ----------------------------------------------------------------
	// command codes and unlock addresses (word mode)
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_UNLOCK1  = 8'haa;
	localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
	localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
	localparam logic [7:0]  CMD_RESET    = 8'hf0;
	localparam logic [7:0]  CMD_QUERY    = 8'h98;
	localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
	localparam logic [7:0]  CMD_BYPASS   = 8'h20;
	localparam logic [7:0]  CMD_SETUP    = 8'h80;
	localparam logic [7:0]  CMD_CHIP     = 8'h10;
	localparam logic [7:0]  CMD_SECTOR   = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
	localparam logic [7:0]  CMD_RESUME   = 8'h30;
	localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
	localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa;
	localparam logic [19:0] ADDR_QUERY   = 20'h00055;
	localparam logic [19:0] ADDR_MAKER   = 20'h00000;
	localparam logic [19:0] ADDR_DEVICE  = 20'h00001;
	localparam logic [19:0] ADDR_PROT    = 20'h00002;
	localparam int          SECT_LSB     = 12;
	// ----------------------------------------------------------------
	// bus timing in 8 ns cycles
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ      = 125;
	localparam int          SETUP_CYC    = 2;
	localparam int          PULSE_CYC    = 4;
	localparam int          HOLD_CYC     = 2;
	localparam int          WIN_US       = 50;
	localparam int          WIN_CYC      = WIN_US * CLK_MHZ;
	localparam int          SUSP_US      = 20;
	localparam int          SUSP_CYC     = SUSP_US * CLK_MHZ;
	// status bit positions on read data
	localparam int          ST_POLL      = 7;
	localparam int          ST_TOG1      = 6;
	localparam int          ST_TLIM      = 5;
	localparam int          ST_EWIN      = 3;
	localparam int          ST_TOG2      = 2;
	// ----------------------------------------------------------------
	// host operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_ID_ENTER, OP_QUERY, OP_PROGRAM, OP_BYP_ENTER,
		OP_BYP_PROGRAM, OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SECT_ADD,
		OP_SUSPEND, OP_RESUME
	} fcdh_op_t;
	typedef struct packed {
		fcdh_op_t    op;
		logic [19:0] addr;
		logic [15:0] data;
	} fcdh_req_t;
	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [19:0] addr;
		logic [15:0] dout;
		logic        doe;
	} fcdh_pins_t;
	typedef struct packed {
		logic        poll;
		logic        tog1;
		logic        tlim;
		logic        ewin;
		logic        tog2;
	} fcdh_stat_t;
endpackage : fcdh_pkg

/* hw/fcdh_seq_rom.sv */
// sequence memory: cycle list for each host operation, registered read
`timescale 1ns/1ns
`default_nettype none
module fcdh_seq_rom (
	// clock
	input  wire logic               ref_clk,
	// lookup
	input  wire fcdh_pkg::fcdh_op_t op,
	input  wire logic [2:0]         idx,
	input  wire logic [19:0]        uaddr,
	input  wire logic [15:0]        udata,
	// step: last flag, read flag, address, data
	output var  logic               last,
	output var  logic               is_read,
	output var  logic [19:0]        addr,
	output var  logic [15:0]        data
);
	// encoded step word: last, read, address, data
	function automatic logic [37:0] step(input logic l, input logic r, input logic [19:0] a, input logic [15:0] d);
		step = {l, r, a, d};
	endfunction : step

	logic [37:0] w;
	// unlock prefixes are shared by id entry, program, bypass entry and both erases
	always_comb begin
		w = step(1'b1, 1'b1, uaddr, udata);
		case (op)
			fcdh_pkg::OP_READ: w = step(1'b1, 1'b1, uaddr, 16'h0000);
			fcdh_pkg::OP_RESET, fcdh_pkg::OP_BYP_EXIT: begin
				if (op == fcdh_pkg::OP_BYP_EXIT && idx == 3'h0) w = step(1'b0, 1'b0, 20'h00000, {8'h00, fcdh_pkg::CMD_AUTOSEL});
				else w = step(1'b1, 1'b0, 20'h00000, {8'h00, fcdh_pkg::CMD_RESET});
			end
			fcdh_pkg::OP_QUERY: w = step(1'b1, 1'b0, fcdh_pkg::ADDR_QUERY, {8'h00, fcdh_pkg::CMD_QUERY});
			fcdh_pkg::OP_SUSPEND: w = step(1'b1, 1'b0, 20'h00000, {8'h00, fcdh_pkg::CMD_SUSPEND});
			fcdh_pkg::OP_RESUME: w = step(1'b1, 1'b0, 20'h00000, {8'h00, fcdh_pkg::CMD_RESUME});
			fcdh_pkg::OP_SECT_ADD: w = step(1'b1, 1'b0, uaddr, {8'h00, fcdh_pkg::CMD_SECTOR});
			fcdh_pkg::OP_BYP_PROGRAM: begin
				if (idx == 3'h0) w = step(1'b0, 1'b0, 20'h00000, {8'h00, fcdh_pkg::CMD_PROGRAM});
				else w = step(1'b1, 1'b0, uaddr, udata);
			end
			default: begin
				case (idx)
					3'h0: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_UNLOCK1});
					3'h1: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK2, {8'h00, fcdh_pkg::CMD_UNLOCK2});
					3'h2: begin
						case (op)
							fcdh_pkg::OP_ID_ENTER: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_AUTOSEL});
							fcdh_pkg::OP_PROGRAM: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_PROGRAM});
							fcdh_pkg::OP_BYP_ENTER: w = step(1'b1, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_BYPASS});
							default: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_SETUP});
						endcase
					end
					3'h3: begin
						if (op == fcdh_pkg::OP_ID_ENTER) w = step(1'b1, 1'b1, uaddr, 16'h0000);
						else if (op == fcdh_pkg::OP_PROGRAM) w = step(1'b1, 1'b0, uaddr, udata);
						else w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_UNLOCK1});
					end
					3'h4: w = step(1'b0, 1'b0, fcdh_pkg::ADDR_UNLOCK2, {8'h00, fcdh_pkg::CMD_UNLOCK2});
					default: begin
						if (op == fcdh_pkg::OP_CHIP_ERASE) w = step(1'b1, 1'b0, fcdh_pkg::ADDR_UNLOCK1, {8'h00, fcdh_pkg::CMD_CHIP});
						else w = step(1'b1, 1'b0, {uaddr[19:fcdh_pkg::SECT_LSB], 12'h000}, {8'h00, fcdh_pkg::CMD_SECTOR});
					end
				endcase
			end
		endcase
	end

	// registered read port
	always_ff @(posedge ref_clk) begin
		{last, is_read, addr, data} <= w;
	end
endmodule : fcdh_seq_rom
`default_nettype wire

/* hw/fcdh_host.sv */
// flash command host: issues command sequences on the flash bus pins
`timescale 1ns/1ns
`default_nettype none
module fcdh_host #(
	parameter int WIN_CYCLES  = fcdh_pkg::WIN_CYC,
	parameter int SUSP_CYCLES = fcdh_pkg::SUSP_CYC
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// user command port
	input  wire logic                req_valid,
	input  wire fcdh_pkg::fcdh_req_t req,
	output var  logic                req_ready,
	output var  logic                done,
	output var  logic [15:0]         rdata,
	output var  fcdh_pkg::fcdh_stat_t stat,
	output var  logic                win_open,
	output var  logic                suspended,
	output var  logic                bypass,
	output var  logic                busy,
	// flash pins
	output var  fcdh_pkg::fcdh_pins_t pins,
	input  wire logic [15:0]         flash_din,
	input  wire logic                ready_busy_line
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// one bus cycle walks fetch, setup, pulse, hold and next; the rom is
	// registered, so fetch spends a clock waiting for the step word
	// setup drives select, address and data some clocks before the strobe
	// falls, so the flash latches a settled address
	// hold keeps the strobe low for the pulse count and then raises it with
	// the data still driven; read data are taken on that same clock
	// next keeps select low for the hold count before moving on, so the
	// flash never sees data change while its strobe rises
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_SETUP, S_PULSE, S_HOLD, S_NEXT} fcdh_st_t;
	typedef struct packed {
		fcdh_st_t            st;
		fcdh_pkg::fcdh_req_t cur;
		logic [2:0]          idx;
		logic [3:0]          cnt;
		logic [15:0]         win;
		logic [15:0]         susp;
		fcdh_pkg::fcdh_pins_t pins;
		logic                ready;
		logic                done;
		logic [15:0]         rdata;
		fcdh_pkg::fcdh_stat_t stat;
		logic                bypass;
		logic                suspended;
		logic                chip;
		logic                busy;
		logic                wopen;
	} fcdh_state_t;
	fcdh_state_t s_r, s_nxt;

	// current step word from the sequence memory
	logic        st_last;
	logic        st_read;
	logic [19:0] st_addr;
	logic [15:0] st_data;

	fcdh_seq_rom u_rom (
		.ref_clk (ref_clk),
		.op      (s_r.cur.op),
		.idx     (s_r.idx),
		.uaddr   (s_r.cur.addr),
		.udata   (s_r.cur.data),
		.last    (st_last),
		.is_read (st_read),
		.addr    (st_addr),
		.data    (st_data)
	);

	// accept filter: refuse ops the flash would treat as invalid
	// refusing here keeps a stray command off the bus, where the flash
	// might drop a running sequence or ignore it without telling us
	function automatic logic op_legal(input fcdh_pkg::fcdh_op_t op, input logic byp, input logic sus,
					  input logic chip, input logic win);
		op_legal = 1'b1;
		if (chip) op_legal = (op == fcdh_pkg::OP_READ);
		else if (byp) op_legal = op == fcdh_pkg::OP_BYP_PROGRAM || op == fcdh_pkg::OP_BYP_EXIT
					 || op == fcdh_pkg::OP_RESET || op == fcdh_pkg::OP_READ;
		else if (op == fcdh_pkg::OP_BYP_PROGRAM || op == fcdh_pkg::OP_BYP_EXIT) op_legal = 1'b0;
		else if (op == fcdh_pkg::OP_SUSPEND) op_legal = !sus;
		else if (op == fcdh_pkg::OP_RESUME) op_legal = sus;
		else if (op == fcdh_pkg::OP_SECT_ADD) op_legal = win;
		else if (sus) op_legal = op == fcdh_pkg::OP_READ || op == fcdh_pkg::OP_PROGRAM
					|| op == fcdh_pkg::OP_ID_ENTER || op == fcdh_pkg::OP_RESET;
	endfunction : op_legal

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.busy = !ready_busy_line;
		// timers run in every state, so a window or a suspend delay keeps
		// counting while a further command is on the bus
		if (s_r.win != 16'h0000) s_nxt.win = s_r.win - 16'h0001;
		if (s_r.susp != 16'h0000) begin
			s_nxt.susp = s_r.susp - 16'h0001;
			if (s_r.susp == 16'h0001) s_nxt.suspended = 1'b1;
		end
		// chip erase is over once the busy line is released again
		if (s_r.chip && ready_busy_line && s_r.win == 16'h0000) s_nxt.chip = 1'b0;
		case (s_r.st)
			S_IDLE: begin
				if (req_valid && s_r.ready) begin
					s_nxt.ready = 1'b0;
					s_nxt.cur = req;
					s_nxt.idx = 3'h0;
					if (op_legal(req.op, s_r.bypass, s_r.suspended || s_r.susp != 16'h0000, s_r.chip,
						     s_r.win != 16'h0000)) begin
						s_nxt.st = S_FETCH;
					end else begin
						// a refused op still answers with done, one clock after it was taken
						s_nxt.done = 1'b1;
						s_nxt.ready = 1'b1;
					end
				end
			end
			// rom answers one cycle after the index moves
			S_FETCH: s_nxt.st = S_SETUP;
			S_SETUP: begin
				s_nxt.pins.ce_n = 1'b0;
				s_nxt.pins.addr = st_addr;
				s_nxt.pins.doe = !st_read;
				s_nxt.pins.dout = st_data;
				s_nxt.cnt = 4'(fcdh_pkg::SETUP_CYC);
				s_nxt.st = S_PULSE;
			end
			S_PULSE: begin
				// address valid before the falling strobe edge
				if (s_r.cnt != 4'h0) s_nxt.cnt = s_r.cnt - 4'h1;
				else begin
					if (st_read) s_nxt.pins.oe_n = 1'b0;
					else s_nxt.pins.we_n = 1'b0;
					s_nxt.cnt = 4'(fcdh_pkg::PULSE_CYC);
					s_nxt.st = S_HOLD;
				end
			end
			S_HOLD: begin
				if (s_r.cnt != 4'h0) s_nxt.cnt = s_r.cnt - 4'h1;
				else begin
					// data held steady over the rising strobe edge
					s_nxt.pins.we_n = 1'b1;
					s_nxt.pins.oe_n = 1'b1;
					if (st_read) begin
						s_nxt.rdata = flash_din;
						s_nxt.stat = '{poll: flash_din[fcdh_pkg::ST_POLL], tog1: flash_din[fcdh_pkg::ST_TOG1],
							       tlim: flash_din[fcdh_pkg::ST_TLIM], ewin: flash_din[fcdh_pkg::ST_EWIN],
							       tog2: flash_din[fcdh_pkg::ST_TOG2]};
					end
					s_nxt.cnt = 4'(fcdh_pkg::HOLD_CYC);
					s_nxt.st = S_NEXT;
				end
			end
			S_NEXT: begin
				// data bus released first; select follows after the hold count
				s_nxt.pins.doe = 1'b0;
				if (s_r.cnt != 4'h0) s_nxt.cnt = s_r.cnt - 4'h1;
				else if (!st_last) begin
					s_nxt.pins.ce_n = 1'b1;
					s_nxt.idx = s_r.idx + 3'h1;
					s_nxt.st = S_FETCH;
				end else begin
					s_nxt.pins.ce_n = 1'b1;
					s_nxt.st = S_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.ready = 1'b1;
					// track mode the flash is now in
					case (s_r.cur.op)
						fcdh_pkg::OP_RESET, fcdh_pkg::OP_BYP_EXIT: s_nxt.bypass = 1'b0;
						fcdh_pkg::OP_BYP_ENTER: s_nxt.bypass = 1'b1;
						fcdh_pkg::OP_CHIP_ERASE: s_nxt.chip = 1'b1;
						fcdh_pkg::OP_SECT_ERASE, fcdh_pkg::OP_SECT_ADD: s_nxt.win = 16'(WIN_CYCLES);
						fcdh_pkg::OP_SUSPEND: begin
							// in the time-out window the suspend is immediate
							if (s_r.win != 16'h0000) s_nxt.suspended = 1'b1;
							else s_nxt.susp = 16'(SUSP_CYCLES);
							s_nxt.win = 16'h0000;
						end
						fcdh_pkg::OP_RESUME: begin
							// a pending suspend delay must not set the flag after resume
							s_nxt.suspended = 1'b0;
							s_nxt.susp = 16'h0000;
						end
						default: ;
					endcase
				end
			end
			default: s_nxt.st = S_IDLE;
		endcase
		// registered copy so the window output comes from a flip-flop
		s_nxt.wopen = s_nxt.win != 16'h0000;
	end

	// state register; reset leaves the bus idle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '{st: S_IDLE, cur: '{op: fcdh_pkg::OP_READ, addr: 20'h00000, data: 16'h0000},
				 idx: 3'h0, cnt: 4'h0, win: 16'h0000, susp: 16'h0000,
				 pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000, dout: 16'h0000, doe: 1'b0},
				 ready: 1'b1, done: 1'b0, rdata: 16'h0000, stat: 5'h00,
				 bypass: 1'b0, suspended: 1'b0, chip: 1'b0, busy: 1'b0, wopen: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign req_ready = s_r.ready;
	assign done      = s_r.done;
	assign rdata     = s_r.rdata;
	assign stat      = s_r.stat;
	assign win_open  = s_r.wopen;
	assign suspended = s_r.suspended;
	assign bypass    = s_r.bypass;
	assign busy      = s_r.busy;
	assign pins      = s_r.pins;
endmodule : fcdh_host
`default_nettype wire

/* bench/fcdh_host_chk.sv */
// checker: bus-cycle assertions for the flash command host
`timescale 1ns/1ns
`default_nettype none
module fcdh_host_chk #(
	parameter int WIN_CYCLES  = fcdh_pkg::WIN_CYC,
	parameter int SUSP_CYCLES = fcdh_pkg::SUSP_CYC
) (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// user side
	input  wire logic                 req_valid,
	input  wire logic                 req_ready,
	input  wire logic                 done,
	input  wire logic                 win_open,
	input  wire logic                 busy,
	// flash side
	input  wire fcdh_pkg::fcdh_pins_t pins,
	input  wire logic                 ready_busy_line
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// window age since the last strobe release; slack covers the hold phase
	int win_cnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			win_cnt <= 0;
		else if (!win_open || $rose(pins.we_n))
			win_cnt <= 0;
		else
			win_cnt <= win_cnt + 1;
	end
	// --------------------------------------------------------------
	// strobe sequences
	// --------------------------------------------------------------
	sequence s_setup; pins.we_n && pins.oe_n ##1 pins.we_n && pins.oe_n; endsequence
	sequence s_pulse; (!pins.we_n && $stable(pins.addr) && $stable(pins.dout))[*3]; endsequence
	property p_ce_setup; $fell(pins.ce_n) |-> s_setup; endproperty
	a_ce_setup: assert property (p_ce_setup) else $error("strobe without setup");
	property p_wr_pulse; $fell(pins.we_n) |-> s_pulse; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse short or moving");
	property p_we_sel; !pins.we_n |-> !pins.ce_n && pins.oe_n; endproperty
	a_we_sel: assert property (p_we_sel) else $error("write strobe without select");
	property p_data_edge; $rose(pins.we_n) |-> pins.doe && !pins.ce_n && $stable(pins.dout); endproperty
	a_data_edge: assert property (p_data_edge) else $error("data not held at strobe rise");
	property p_read_bus; !pins.oe_n |-> !pins.doe && pins.we_n; endproperty
	a_read_bus: assert property (p_read_bus) else $error("read while driving data");
	property p_take; req_valid && req_ready |=> (!req_ready && !done) || (req_ready && done); endproperty
	a_take: assert property (p_take) else $error("request not held off");
	property p_idle; req_ready |-> pins.ce_n && !pins.doe; endproperty
	a_idle: assert property (p_idle) else $error("bus active while idle");
	property p_busy; 1'b1 |=> busy == !$past(ready_busy_line); endproperty
	a_busy: assert property (p_busy) else $error("busy not following line");
	property p_win; win_cnt <= WIN_CYCLES + 8; endproperty
	a_win: assert property (p_win) else $error("window open too long");
endmodule : fcdh_host_chk
`default_nettype wire

/* bench/fcdh_flash_model.sv */
// flash memory model: command decoder, id codes and array data
`timescale 1ns/1ns
`default_nettype none
module fcdh_flash_model #(
	parameter logic [15:0] MAKER_ID  = 16'h0011, // arbitrary value
	parameter logic [15:0] DEVICE_ID = 16'h0022  // arbitrary value
) (
	// reset and pins
	input  wire logic                 rst,
	input  wire fcdh_pkg::fcdh_pins_t pins,
	output var  logic [15:0]          flash_din,
	output var  logic                 ready_busy_line,
	// last sequence decoded
	output var  fcdh_pkg::fcdh_op_t   seen
);
	typedef enum {M_ARR, M_ID, M_BYP, M_CHIP, M_SECT, M_SUSP} fcdh_mode_t;
	fcdh_mode_t  mode;
	logic [2:0]  cyc;
	logic [19:0] la;
	logic [19:0] pa = '1; // nothing programmed before the first reset
	logic [15:0] pd;
	logic [10:0] a, ea;
	logic [7:0]  d;
	wire         wr = !pins.ce_n && !pins.we_n;
	// address taken as the later strobe falls
	always @(posedge wr) la = pins.addr;
	// chip erase finishes on its own; only a timer, no real algorithm
	// timed from entry and off the rising edge, so the busy line never races the host
	always @(mode) begin
		if (mode == M_CHIP) begin
			#3004;
			mode = M_ARR;
		end
	end
	// record a decoded sequence and restart the cycle count
	task automatic go_mode(input fcdh_mode_t m, input fcdh_pkg::fcdh_op_t o);
		mode = m;
		seen = o;
		cyc = 3'd0;
	endtask : go_mode
	// open drain with pull-up: low only while erasing
	always_comb ready_busy_line = (mode != M_CHIP) && (mode != M_SECT);
	// data taken as the first strobe rises, then decoded
	always @(negedge wr or posedge rst) begin
		if (rst) begin
			mode = M_ARR;
			cyc = 3'd0;
			seen = fcdh_pkg::OP_READ;
			pa = '1;
			pd = 16'h0;
			flash_din = 16'h5a5a;
		end else begin
			d = pins.dout[7:0];
			a = la[10:0];
			ea = (cyc == 3'd0 && d == 8'h98) ? 11'h055 : (cyc == 3'd1 || cyc == 3'd5) ? 11'h2aa : 11'h555;
			if (mode == M_CHIP) begin
				cyc = 3'd0;
			end else if (mode == M_BYP) begin
				if (cyc == 3'd1) begin
					{pa, pd} = {la, pins.dout};
					seen = fcdh_pkg::OP_BYP_PROGRAM;
					cyc = 3'd0;
				end else if (d == 8'hf0) begin
					go_mode(M_ARR, fcdh_pkg::OP_BYP_EXIT);
				end else
					cyc = (d == 8'ha0) ? 3'd1 : (d == 8'h90) ? 3'd2 : 3'd0;
			end else if (mode == M_SECT) begin
				if (d == 8'hb0) go_mode(M_SUSP, fcdh_pkg::OP_SUSPEND);
				else if (d == 8'h30) seen = fcdh_pkg::OP_SECT_ADD;
			end else if (mode == M_SUSP && d == 8'h30 && cyc == 3'd0) begin
				go_mode(M_SECT, fcdh_pkg::OP_RESUME);
			end else if (d == 8'hf0) begin
				go_mode(M_ARR, fcdh_pkg::OP_RESET);
			end else if (cyc == 3'd3) begin
				{pa, pd} = {la, pins.dout};
				go_mode(mode, fcdh_pkg::OP_PROGRAM);
			end else if (cyc == 3'd6 && d == 8'h30) begin
				go_mode(M_SECT, fcdh_pkg::OP_SECT_ERASE);
			end else if (a != ea) begin
				cyc = 3'd0;
			end else begin
				case ({cyc, d})
					{3'd0, 8'haa}, {3'd1, 8'h55}, {3'd4, 8'haa}, {3'd5, 8'h55}: cyc = cyc + 3'd1;
					{3'd2, 8'ha0}: cyc = 3'd3;
					{3'd2, 8'h80}: cyc = 3'd4;
					{3'd2, 8'h90}: go_mode(M_ID, fcdh_pkg::OP_ID_ENTER);
					{3'd2, 8'h20}: go_mode(M_BYP, fcdh_pkg::OP_BYP_ENTER);
					{3'd6, 8'h10}: go_mode(M_CHIP, fcdh_pkg::OP_CHIP_ERASE);
					{3'd0, 8'h98}: if (mode != M_SUSP) seen = fcdh_pkg::OP_QUERY;
					default: cyc = 3'd0;
				endcase
			end
		end
	end
	// read data; released bus shows the inverse of its last value
	always @(pins.ce_n, pins.oe_n, pins.addr) begin
		if (!pins.ce_n && !pins.oe_n && mode == M_ID)
			flash_din = (pins.addr[1:0] == 2'd0) ? MAKER_ID : (pins.addr[1:0] == 2'd1) ? DEVICE_ID
				: {15'h0, pins.addr[19:12] == 8'h00};
		else if (!pins.ce_n && !pins.oe_n)
			flash_din = (pins.addr == pa) ? pd : ~pins.addr[15:0];
		else
			flash_din = ~flash_din;
	end
endmodule : fcdh_flash_model
`default_nettype wire

/* bench/fcdh_host_tb.sv */
// testbench: command sequences through the host controller into a flash model
`timescale 1ns/1ns
`default_nettype none
module fcdh_host_tb;
	typedef struct packed {
		fcdh_pkg::fcdh_op_t op;
		logic [19:0]        addr;
		logic [15:0]        data;
		fcdh_pkg::fcdh_op_t seen;
		logic               rd;
		logic [15:0]        exp;
	} fcdh_row_t;
	localparam int          WIN = 200;
	localparam logic [15:0] MID = 16'h0011; // arbitrary value
	localparam logic [15:0] DID = 16'h0022; // arbitrary value
	localparam fcdh_row_t ROWS [13] = '{
		'{fcdh_pkg::OP_RESET, 20'h0, 16'h0, fcdh_pkg::OP_RESET, 1'b0, 16'h0},
		'{fcdh_pkg::OP_READ, 20'h12345, 16'h0, fcdh_pkg::OP_RESET, 1'b1, 16'hdcba},
		'{fcdh_pkg::OP_ID_ENTER, 20'h0, 16'h0, fcdh_pkg::OP_ID_ENTER, 1'b1, MID},
		'{fcdh_pkg::OP_RESET, 20'h0, 16'h0, fcdh_pkg::OP_RESET, 1'b0, 16'h0},
		'{fcdh_pkg::OP_ID_ENTER, 20'h1, 16'h0, fcdh_pkg::OP_ID_ENTER, 1'b1, DID},
		'{fcdh_pkg::OP_QUERY, 20'h0, 16'h0, fcdh_pkg::OP_QUERY, 1'b0, 16'h0},
		'{fcdh_pkg::OP_ID_ENTER, 20'h2, 16'h0, fcdh_pkg::OP_ID_ENTER, 1'b1, 16'h0001},
		'{fcdh_pkg::OP_RESET, 20'h0, 16'h0, fcdh_pkg::OP_RESET, 1'b0, 16'h0},
		'{fcdh_pkg::OP_PROGRAM, 20'h23a5c, 16'hbeef, fcdh_pkg::OP_PROGRAM, 1'b0, 16'h0},
		'{fcdh_pkg::OP_READ, 20'h23a5c, 16'h0, fcdh_pkg::OP_PROGRAM, 1'b1, 16'hbeef},
		'{fcdh_pkg::OP_BYP_ENTER, 20'h0, 16'h0, fcdh_pkg::OP_BYP_ENTER, 1'b0, 16'h0},
		'{fcdh_pkg::OP_BYP_PROGRAM, 20'h1f00f, 16'h1234, fcdh_pkg::OP_BYP_PROGRAM, 1'b0, 16'h0},
		'{fcdh_pkg::OP_BYP_EXIT, 20'h0, 16'h0, fcdh_pkg::OP_BYP_EXIT, 1'b0, 16'h0}
	};
	logic                 ref_clk   = 1'b0;
	logic                 rst       = 1'b1;
	logic                 req_valid = 1'b0;
	fcdh_pkg::fcdh_req_t  req       = '0;
	logic                 req_ready, done, win_open, suspended, bypass, busy, rb;
	logic [15:0]          rdata, din;
	fcdh_pkg::fcdh_stat_t stat;
	fcdh_pkg::fcdh_pins_t pins;
	fcdh_pkg::fcdh_op_t   seen;
	int                   fail_count = 0, cmp_count = 0, ce_cnt = 0, n;
	fcdh_host #(.WIN_CYCLES(WIN), .SUSP_CYCLES(20)) i_fcdh_host (.ref_clk(ref_clk), .rst(rst),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .stat(stat),
		.win_open(win_open), .suspended(suspended), .bypass(bypass), .busy(busy), .pins(pins),
		.flash_din(din), .ready_busy_line(rb));
	fcdh_flash_model #(.MAKER_ID(MID), .DEVICE_ID(DID)) i_fcdh_flash_model (.rst(rst), .pins(pins),
		.flash_din(din), .ready_busy_line(rb), .seen(seen));
	// clock and select counter; refused requests must leave the bus quiet
	always #4 ref_clk = ~ref_clk;
	always @(negedge pins.ce_n) ce_cnt++;
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// bounded wait at falling edges; running out ends the run
	task automatic wait_on(ref logic sig, input logic lvl, input int lim);
		for (int k = 0; k < lim && sig !== lvl; k++) @(negedge ref_clk);
		if (sig !== lvl) begin
			chk(20'(sig), 20'(lvl));
			end_of_test();
		end
	endtask : wait_on
	task automatic run(input fcdh_pkg::fcdh_op_t op, input logic [19:0] a, input logic [15:0] d);
		wait_on(req_ready, 1'b1, 50);
		req_valid = 1'b1;
		req = '{op, a, d};
		@(negedge ref_clk);
		req_valid = 1'b0;
		wait_on(done, 1'b1, 400);
		@(negedge ref_clk);
	endtask : run
	initial begin
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		foreach (ROWS[k]) begin
			run(ROWS[k].op, ROWS[k].addr, ROWS[k].data);
			chk(20'(seen), 20'(ROWS[k].seen));
			if (ROWS[k].rd) chk(20'(rdata), 20'(ROWS[k].exp));
			if (ROWS[k].rd) chk(20'(stat), 20'({ROWS[k].exp[7:5], ROWS[k].exp[3:2]}));
			$display("row %0d finished", k);
		end
		// reset in mid-sequence, then a clean program
		req = '{fcdh_pkg::OP_PROGRAM, 20'h00100, 16'h0abc};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		repeat (30) @(negedge ref_clk);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		chk({18'(seen), pins.ce_n, req_ready}, {18'(fcdh_pkg::OP_READ), 2'b11});
		run(fcdh_pkg::OP_PROGRAM, 20'h00100, 16'h0abc);
		chk(20'(seen), 20'(fcdh_pkg::OP_PROGRAM));
		$display("reset test finished");
		// chip erase: suspend refused while busy
		run(fcdh_pkg::OP_CHIP_ERASE, 20'h0, 16'h0);
		chk(20'(seen), 20'(fcdh_pkg::OP_CHIP_ERASE));
		wait_on(busy, 1'b1, 50);
		n = ce_cnt;
		run(fcdh_pkg::OP_SUSPEND, 20'h0, 16'h0);
		chk(20'(ce_cnt - n), 20'h0);
		wait_on(busy, 1'b0, 800);
		$display("chip erase test finished");
		// bypass: chip erase refused, single reset exits
		run(fcdh_pkg::OP_BYP_ENTER, 20'h0, 16'h0);
		chk(20'(bypass), 20'h1);
		n = ce_cnt;
		run(fcdh_pkg::OP_CHIP_ERASE, 20'h0, 16'h0);
		chk(20'(ce_cnt - n), 20'h0);
		run(fcdh_pkg::OP_RESET, 20'h0, 16'h0);
		chk({19'(seen), bypass}, {19'(fcdh_pkg::OP_BYP_EXIT), 1'b0});
		$display("bypass test finished");
		// sector erase window, late add refused, suspend, program, resume
		run(fcdh_pkg::OP_SECT_ERASE, 20'h45000, 16'h0);
		chk({19'(seen), win_open}, {19'(fcdh_pkg::OP_SECT_ERASE), 1'b1});
		run(fcdh_pkg::OP_SECT_ADD, 20'h46000, 16'h0);
		chk(20'(seen), 20'(fcdh_pkg::OP_SECT_ADD));
		repeat (WIN + 50) @(negedge ref_clk);
		n = ce_cnt;
		run(fcdh_pkg::OP_SECT_ADD, 20'h47000, 16'h0);
		chk({19'(ce_cnt - n), win_open}, 20'h00000);
		run(fcdh_pkg::OP_SUSPEND, 20'h0, 16'h0);
		wait_on(suspended, 1'b1, 60);
		chk(20'(seen), 20'(fcdh_pkg::OP_SUSPEND));
		run(fcdh_pkg::OP_PROGRAM, 20'h00200, 16'h5555);
		chk(20'(seen), 20'(fcdh_pkg::OP_PROGRAM));
		run(fcdh_pkg::OP_RESUME, 20'h0, 16'h0);
		chk({19'(seen), suspended}, {19'(fcdh_pkg::OP_RESUME), 1'b0});
		$display("sector erase test finished");
		end_of_test();
	end
endmodule : fcdh_host_tb
bind fcdh_host fcdh_host_chk #(.WIN_CYCLES(WIN_CYCLES), .SUSP_CYCLES(SUSP_CYCLES)) i_fcdh_host_chk (
	.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .done(done),
	.win_open(win_open), .busy(busy), .pins(pins), .ready_busy_line(ready_busy_line));
`default_nettype wire
